// file: core/disk_ctrl_enhanced_cmd_set.sv
// Command interpreter of the enhanced disk controller firmware, AXI4-Lite host side
`timescale 1ns/1ps
`include "disk_ctrl_consts.svh"
module disk_ctrl_enhanced_cmd_set #(
	parameter int CLK_MHZ = 20,
	parameter int SERVO_GAP_US = 300,
	parameter int STEP_SLOW_US = 3000
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic drv_op_valid,
	output disk_ctrl_pkg::drv_op_t drv_op,
	output logic [15:0] drv_cyl,
	output logic [3:0] drv_head,
	output logic drv_sel,
	output logic drv_fill_buffer,
	output logic [15:0] drv_gap_cycles,
	output logic [15:0] drv_step_cycles,
	output logic [5:0] drv_sectors,
	output logic [79:0] cfg_image,
	input wire logic drv_done,
	input wire logic drv_err,
	input wire logic drv_rvalid,
	input wire logic [7:0] drv_rdata,
	input wire logic ecc_burst_valid,
	input wire logic [3:0] ecc_burst_len,
	output logic ecc_uncorrectable
);
	localparam int GAP_CYC = SERVO_GAP_US * CLK_MHZ;
	localparam int SLOW_CYC = STEP_SLOW_US * CLK_MHZ;

	if (CLK_MHZ < 1 || GAP_CYC > 65535 || SLOW_CYC > 65535) begin : g_chk
		$error("clock rate or delays do not fit 16-bit counts");
	end

	function automatic logic [15:0] step_cyc(input logic [3:0] code);
		int us;
		case (code)
			`STEP_200: us = `STEP_200_US;
			`STEP_70: us = `STEP_70_US;
			`STEP_30: us = `STEP_30_US;
			`STEP_15: us = `STEP_15_US;
			`STEP_12: us = `STEP_12_US;
			default: us = STEP_SLOW_US;
		endcase
		return 16'(us * CLK_MHZ);
	endfunction

	function automatic logic cfg_ok(input logic [79:0] c);
		logic ok;
		ok = (c[`CFG_HEAD] != 4'h0) && (c[`CFG_CYL] > 16'h0001);
		ok = ok && (c[`CFG_SIZE] == `SIZE_256 || c[`CFG_SIZE] == `SIZE_512);
		ok = ok && (c[`CFG_STEP] == `STEP_SLOW
			|| (c[`CFG_STEP] >= `STEP_200 && c[`CFG_STEP] <= `STEP_12));
		ok = ok && (c[`CFG_TYPE] <= `TYPE_MAX);
		ok = ok && (c[`CFG_BURST] != 4'h0) && (c[`CFG_BURST] <= `BURST_MAX);
		ok = ok && (c[`CFG_RWC] <= c[`CFG_CYL]) && (c[`CFG_PRE] <= c[`CFG_CYL]);
		return ok;
	endfunction

	disk_ctrl_pkg::ctrl_state_t state_reg;
	logic [47:0] cmd_reg;
	logic [79:0] in_reg;
	logic [79:0] cfg_reg;
	logic [79:0] out_reg;
	logic cfg_valid_reg;
	logic [3:0] cnt_reg;
	logic [3:0] need_reg;
	logic [7:0] err_reg;
	logic [15:0] tracks_reg;
	logic [20:0] rem_reg;
	logic [15:0] cyl_reg;
	logic [3:0] head_reg;
	logic push_reg;
	logic [7:0] push_data_reg;
	logic pop_reg;
	logic host_req;
	logic host_io;
	logic host_cd;
	logic [7:0] host_byte;
	logic [5:0] spt;
	logic [15:0] cyl_cnt;
	logic [3:0] head_max;
	logic last_trk;
	logic [31:0] rd_word;

	// Sector count derives from the configured size alone, the board jumper has no say
	assign spt = (cfg_reg[`CFG_SIZE] == `SIZE_512) ? `SPT_512 : `SPT_256;
	assign cyl_cnt = cfg_reg[`CFG_CYL];
	assign head_max = cfg_reg[`CFG_HEAD] - 4'h1;
	assign last_trk = (cyl_reg == cyl_cnt - 16'h0001) && (head_reg == head_max);
	assign drv_cyl = cyl_reg;
	assign drv_head = head_reg;

	always_comb begin
		host_req = 1'b0;
		host_io = 1'b0;
		host_cd = 1'b0;
		host_byte = `NULL_BYTE;
		case (state_reg)
			disk_ctrl_pkg::ST_CMD: begin
				host_req = 1'b1;
				host_cd = 1'b1;
			end
			disk_ctrl_pkg::ST_DIN: begin
				host_req = 1'b1;
			end
			disk_ctrl_pkg::ST_DOUT: begin
				host_req = 1'b1;
				host_io = 1'b1;
				host_byte = out_reg[79:72];
			end
			disk_ctrl_pkg::ST_STAT: begin
				host_req = 1'b1;
				host_io = 1'b1;
				host_cd = 1'b1;
				host_byte = (err_reg != `ERR_NONE) ? `STAT_ERR : `STAT_OK;
			end
			disk_ctrl_pkg::ST_NULL: begin
				host_req = 1'b1;
				host_io = 1'b1;
				host_cd = 1'b1;
			end
			default: begin
				host_req = 1'b0;
			end
		endcase
	end

	always_comb begin
		case (s_axi_araddr)
			`OFF_DATA: rd_word = {24'h000000, host_req && host_io ? host_byte : 8'h00};
			`OFF_STAT: rd_word = {16'h0000, err_reg, 3'h0, cfg_valid_reg,
				state_reg != disk_ctrl_pkg::ST_CMD, host_cd, host_io, host_req};
			`OFF_ERR: rd_word = {24'h000000, err_reg};
			default: rd_word = 32'h00000000;
		endcase
	end

	// Address and data are taken together, so a lone channel simply waits
	always_ff @(posedge core_clk) begin
		if (reset) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OK;
			push_reg <= 1'b0;
			push_data_reg <= 8'h00;
		end else begin
			push_reg <= 1'b0;
			if (s_axi_awready) begin
				s_axi_awready <= 1'b0;
				s_axi_wready <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (s_axi_awaddr == `OFF_DATA || s_axi_awaddr == `OFF_STAT
					|| s_axi_awaddr == `OFF_ERR) ? `RESP_OK : `RESP_SLVERR;
				push_reg <= (s_axi_awaddr == `OFF_DATA) && s_axi_wstrb[0] && host_req && !host_io;
				push_data_reg <= s_axi_wdata[7:0];
			end else if (s_axi_bvalid) begin
				if (s_axi_bready) begin
					s_axi_bvalid <= 1'b0;
				end
			end else if (s_axi_awvalid && s_axi_wvalid) begin
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OK;
			pop_reg <= 1'b0;
		end else begin
			pop_reg <= 1'b0;
			if (s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= (s_axi_araddr == `OFF_DATA || s_axi_araddr == `OFF_STAT
					|| s_axi_araddr == `OFF_ERR) ? `RESP_OK : `RESP_SLVERR;
				pop_reg <= (s_axi_araddr == `OFF_DATA) && host_req && host_io;
			end else if (s_axi_rvalid) begin
				if (s_axi_rready) begin
					s_axi_rvalid <= 1'b0;
				end
			end else if (s_axi_arvalid) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_reg <= disk_ctrl_pkg::ST_LOAD;
			cmd_reg <= 48'h000000000000;
			in_reg <= 80'h0;
			cfg_reg <= 80'h0;
			out_reg <= 80'h0;
			cfg_valid_reg <= 1'b0;
			cnt_reg <= 4'h0;
			need_reg <= 4'h0;
			err_reg <= `ERR_NONE;
			tracks_reg <= 16'h0000;
			rem_reg <= 21'h000000;
			cyl_reg <= 16'h0000;
			head_reg <= 4'h0;
			drv_op_valid <= 1'b0;
			drv_op <= disk_ctrl_pkg::DOP_NONE;
			drv_sel <= 1'b0;
			drv_fill_buffer <= 1'b0;
		end else begin
			drv_op_valid <= 1'b0;
			case (state_reg)
				disk_ctrl_pkg::ST_LOAD: begin
					cyl_reg <= 16'h0000;
					head_reg <= 4'h0;
					drv_op <= disk_ctrl_pkg::DOP_RDCFG;
					drv_op_valid <= 1'b1;
					cnt_reg <= 4'h0;
					state_reg <= disk_ctrl_pkg::ST_LOADWAIT;
				end
				disk_ctrl_pkg::ST_LOADWAIT: begin
					if (drv_rvalid) begin
						in_reg <= {in_reg[71:0], drv_rdata};
						cnt_reg <= cnt_reg + 4'h1;
					end
					// A failed or short load leaves the controller uninitialised
					if (drv_done) begin
						if (!drv_err && cnt_reg == `LEN_CFG && cfg_ok(in_reg)) begin
							cfg_reg <= in_reg;
							cfg_valid_reg <= 1'b1;
						end
						cnt_reg <= 4'h0;
						state_reg <= disk_ctrl_pkg::ST_CMD;
					end
				end
				disk_ctrl_pkg::ST_CMD: begin
					if (push_reg) begin
						cmd_reg <= {cmd_reg[39:0], push_data_reg};
						if (cnt_reg == `LEN_CMD - 4'h1) begin
							cnt_reg <= 4'h0;
							state_reg <= disk_ctrl_pkg::ST_DECODE;
						end else begin
							cnt_reg <= cnt_reg + 4'h1;
						end
					end
				end
				disk_ctrl_pkg::ST_DECODE: begin
					err_reg <= `ERR_NONE;
					drv_sel <= cmd_reg[`CMD_DRV];
					state_reg <= disk_ctrl_pkg::ST_STAT;
					if (cmd_reg[`CMD_CLASS] != 3'h0) begin
						err_reg <= `ERR_BAD_CMD;
					end else begin
						case (cmd_reg[`CMD_OP])
							`OP_FMT: begin
								if (!cfg_valid_reg) begin
									err_reg <= `ERR_NOT_INIT;
								end else begin
									need_reg <= `LEN_CNT;
									state_reg <= disk_ctrl_pkg::ST_DIN;
								end
							end
							`OP_INIT: begin
								need_reg <= `LEN_CFG;
								state_reg <= disk_ctrl_pkg::ST_DIN;
							end
							`OP_LEGACY: begin
								need_reg <= `LEN_LEGACY;
								state_reg <= disk_ctrl_pkg::ST_DIN;
							end
							`OP_RDCFG: begin
								if (!cfg_valid_reg) begin
									err_reg <= `ERR_NOT_INIT;
								end else begin
									out_reg <= cfg_reg;
									state_reg <= disk_ctrl_pkg::ST_DOUT;
								end
							end
							`OP_STOP: begin
								if (!cfg_valid_reg) begin
									err_reg <= `ERR_NOT_INIT;
								end else begin
									drv_op <= disk_ctrl_pkg::DOP_STOP;
									drv_op_valid <= 1'b1;
									state_reg <= disk_ctrl_pkg::ST_STOP;
								end
							end
							default: begin
								err_reg <= `ERR_BAD_CMD;
							end
						endcase
					end
				end
				disk_ctrl_pkg::ST_DIN: begin
					if (push_reg) begin
						in_reg <= {in_reg[71:0], push_data_reg};
						if (cnt_reg == need_reg - 4'h1) begin
							cnt_reg <= 4'h0;
							state_reg <= disk_ctrl_pkg::ST_APPLY;
						end else begin
							cnt_reg <= cnt_reg + 4'h1;
						end
					end
				end
				disk_ctrl_pkg::ST_APPLY: begin
					state_reg <= disk_ctrl_pkg::ST_STAT;
					if (cmd_reg[`CMD_OP] == `OP_FMT) begin
						tracks_reg <= in_reg[15:0];
						drv_fill_buffer <= cmd_reg[`BIT_FILL];
						rem_reg <= cmd_reg[`CMD_LBA];
						head_reg <= 4'h0;
						if (in_reg[15:0] == 16'h0000) begin
							cyl_reg <= 16'h0000;
							drv_op <= disk_ctrl_pkg::DOP_WRCFG;
							drv_op_valid <= 1'b1;
							state_reg <= disk_ctrl_pkg::ST_WRCFG;
						end else begin
							cyl_reg <= 16'h0001;
							state_reg <= disk_ctrl_pkg::ST_CALC;
						end
					end else if (cmd_reg[`CMD_OP] == `OP_INIT) begin
						if (cfg_ok(in_reg)) begin
							cfg_reg <= in_reg;
							cfg_valid_reg <= 1'b1;
						end else begin
							err_reg <= `ERR_ILL_PARAM;
						end
					end
				end
				// One track per cycle; slow for far addresses but keeps out a divider
				disk_ctrl_pkg::ST_CALC: begin
					if (cyl_reg >= cyl_cnt) begin
						err_reg <= `ERR_ILL_ADDR;
						state_reg <= disk_ctrl_pkg::ST_STAT;
					end else if (rem_reg >= 21'(spt)) begin
						rem_reg <= rem_reg - 21'(spt);
						if (head_reg == head_max) begin
							head_reg <= 4'h0;
							cyl_reg <= cyl_reg + 16'h0001;
						end else begin
							head_reg <= head_reg + 4'h1;
						end
					end else begin
						drv_op <= disk_ctrl_pkg::DOP_RECAL;
						drv_op_valid <= 1'b1;
						state_reg <= disk_ctrl_pkg::ST_RECAL;
					end
				end
				disk_ctrl_pkg::ST_RECAL: begin
					if (drv_done) begin
						if (drv_err) begin
							err_reg <= `ERR_DRIVE;
							state_reg <= disk_ctrl_pkg::ST_STAT;
						end else begin
							drv_op <= disk_ctrl_pkg::DOP_SEEK;
							drv_op_valid <= 1'b1;
							state_reg <= disk_ctrl_pkg::ST_SEEK;
						end
					end
				end
				disk_ctrl_pkg::ST_SEEK: begin
					if (drv_done) begin
						if (drv_err) begin
							err_reg <= `ERR_DRIVE;
							state_reg <= disk_ctrl_pkg::ST_STAT;
						end else begin
							drv_op <= disk_ctrl_pkg::DOP_FORMAT;
							drv_op_valid <= 1'b1;
							state_reg <= disk_ctrl_pkg::ST_FMT;
						end
					end
				end
				disk_ctrl_pkg::ST_FMT: begin
					if (drv_done) begin
						tracks_reg <= tracks_reg - 16'h0001;
						if (drv_err) begin
							err_reg <= `ERR_DRIVE;
							state_reg <= disk_ctrl_pkg::ST_STAT;
						end else if (tracks_reg == 16'h0001 || last_trk) begin
							// Formatted drive keeps its configuration on the reserved cylinder
							if (tracks_reg != 16'h0001) begin
								err_reg <= `ERR_ILL_ADDR;
							end
							cyl_reg <= 16'h0000;
							head_reg <= 4'h0;
							drv_op <= disk_ctrl_pkg::DOP_WRCFG;
							drv_op_valid <= 1'b1;
							state_reg <= disk_ctrl_pkg::ST_WRCFG;
						end else begin
							if (head_reg == head_max) begin
								head_reg <= 4'h0;
								cyl_reg <= cyl_reg + 16'h0001;
							end else begin
								head_reg <= head_reg + 4'h1;
							end
							drv_op <= disk_ctrl_pkg::DOP_FORMAT;
							drv_op_valid <= 1'b1;
						end
					end
				end
				disk_ctrl_pkg::ST_WRCFG, disk_ctrl_pkg::ST_STOP: begin
					if (drv_done) begin
						if (drv_err) begin
							err_reg <= `ERR_DRIVE;
						end
						state_reg <= disk_ctrl_pkg::ST_STAT;
					end
				end
				disk_ctrl_pkg::ST_DOUT: begin
					if (pop_reg) begin
						out_reg <= {out_reg[71:0], 8'h00};
						if (cnt_reg == `LEN_CFG - 4'h1) begin
							cnt_reg <= 4'h0;
							state_reg <= disk_ctrl_pkg::ST_STAT;
						end else begin
							cnt_reg <= cnt_reg + 4'h1;
						end
					end
				end
				disk_ctrl_pkg::ST_STAT: begin
					if (pop_reg) begin
						state_reg <= disk_ctrl_pkg::ST_NULL;
					end
				end
				disk_ctrl_pkg::ST_NULL: begin
					if (pop_reg) begin
						state_reg <= disk_ctrl_pkg::ST_CMD;
					end
				end
				default: begin
					state_reg <= disk_ctrl_pkg::ST_CMD;
				end
			endcase
		end
	end

	// Drive timing follows the stored configuration, never the command control byte
	always_ff @(posedge core_clk) begin
		if (reset) begin
			drv_gap_cycles <= 16'h0000;
			drv_step_cycles <= 16'h0000;
			drv_sectors <= 6'h00;
			cfg_image <= 80'h0;
		end else begin
			drv_gap_cycles <= cfg_reg[`CFG_SERVO] ? 16'(GAP_CYC) : 16'h0000;
			drv_step_cycles <= step_cyc(cfg_reg[`CFG_STEP]);
			drv_sectors <= spt;
			cfg_image <= cfg_reg;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			ecc_uncorrectable <= 1'b0;
		end else begin
			ecc_uncorrectable <= ecc_burst_valid && (ecc_burst_len > cfg_reg[`CFG_BURST]);
		end
	end
endmodule

// file: core/disk_ctrl_consts.svh
// Offsets, codes, field positions and timing figures of the command interpreter
`ifndef DISK_CTRL_CONSTS_SVH
`define DISK_CTRL_CONSTS_SVH
`define OFF_DATA 8'h00
`define OFF_STAT 8'h04
`define OFF_ERR 8'h08
`define RESP_OK 2'h0
`define RESP_SLVERR 2'h2
`define OP_FMT 5'h06
`define OP_LEGACY 5'h0C
`define OP_INIT 5'h11
`define OP_RDCFG 5'h12
`define OP_STOP 5'h13
`define ERR_NONE 8'h00
`define ERR_DRIVE 8'h02
`define ERR_NOT_INIT 8'h0A
`define ERR_BAD_CMD 8'h20
`define ERR_ILL_ADDR 8'h21
`define ERR_ILL_PARAM 8'h22
`define STAT_ERR 8'h02
`define STAT_OK 8'h00
`define NULL_BYTE 8'h00
`define LEN_CMD 4'h6
`define LEN_CNT 4'h2
`define LEN_CFG 4'hA
`define LEN_LEGACY 4'h8
`define BIT_FILL 5
`define CMD_CLASS 47:45
`define CMD_OP 44:40
`define CMD_DRV 37
`define CMD_LBA 36:16
`define CFG_CYL 79:64
`define CFG_HEAD 59:56
`define CFG_STEP 55:52
`define CFG_TYPE 51:49
`define CFG_SERVO 48
`define CFG_SIZE 41:40
`define CFG_RWC 39:24
`define CFG_PRE 23:8
`define CFG_BURST 3:0
`define SIZE_256 2'h1
`define SIZE_512 2'h2
`define SPT_256 6'h20
`define SPT_512 6'h11
`define BURST_MAX 4'hB
`define TYPE_MAX 3'h1
`define STEP_SLOW 4'h0
`define STEP_200 4'h4
`define STEP_70 4'h5
`define STEP_30 4'h6
`define STEP_15 4'h7
`define STEP_12 4'h8
`define STEP_200_US 200
`define STEP_70_US 70
`define STEP_30_US 30
`define STEP_15_US 15
`define STEP_12_US 12
`endif

// file: core/disk_ctrl_pkg.sv
// Types shared by the command interpreter
package disk_ctrl_pkg;
	typedef enum logic [3:0] {
		ST_CMD = 4'h0,
		ST_DECODE = 4'h1,
		ST_DIN = 4'h3,
		ST_CALC = 4'h2,
		ST_RECAL = 4'h6,
		ST_SEEK = 4'h7,
		ST_FMT = 4'h5,
		ST_STAT = 4'h4,
		ST_NULL = 4'hC,
		ST_DOUT = 4'hD,
		ST_WRCFG = 4'hF,
		ST_STOP = 4'hE,
		ST_APPLY = 4'h8,
		ST_LOAD = 4'hA,
		ST_LOADWAIT = 4'hB
	} ctrl_state_t;
	typedef enum logic [2:0] {
		DOP_NONE = 3'h0,
		DOP_RECAL = 3'h1,
		DOP_SEEK = 3'h2,
		DOP_FORMAT = 3'h3,
		DOP_WRCFG = 3'h4,
		DOP_RDCFG = 3'h5,
		DOP_STOP = 3'h6
	} drv_op_t;
endpackage

// file: sim/disk_ctrl_asserts.sv
// Assertions on the interpreter's bus and drive-engine ports
`timescale 1ns/1ps
`include "disk_ctrl_consts.svh"
module disk_ctrl_asserts #(
	parameter int CLK_MHZ = 20,
	parameter int SERVO_GAP_US = 300
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic s_axi_awready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic drv_op_valid,
	input wire disk_ctrl_pkg::drv_op_t drv_op,
	input wire logic [15:0] drv_cyl,
	input wire logic [15:0] drv_gap_cycles,
	input wire logic [5:0] drv_sectors,
	input wire logic [79:0] cfg_image,
	input wire logic ecc_burst_valid,
	input wire logic [3:0] ecc_burst_len,
	input wire logic ecc_uncorrectable
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	logic fmt_op;
	assign fmt_op = drv_op_valid && drv_op == disk_ctrl_pkg::DOP_FORMAT;
	property p_wr_answer;
		s_axi_awready |=> s_axi_bvalid;
	endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write response late");
	property p_bresp_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");
	property p_rd_answer;
		s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read response late");
	property p_burst_limit;
		ecc_burst_valid |=> ecc_uncorrectable == ($past(ecc_burst_len) > $past(cfg_image[`CFG_BURST]));
	endproperty
	a_burst_limit: assert property (p_burst_limit) else $error("burst flag wrong");
	property p_sectors;
		fmt_op |-> drv_sectors == (cfg_image[`CFG_SIZE] == `SIZE_256 ? `SPT_256 : `SPT_512);
	endproperty
	a_sectors: assert property (p_sectors) else $error("sectors per track wrong");
	property p_servo_gap;
		fmt_op |-> drv_gap_cycles == (cfg_image[`CFG_SERVO] ? 16'(SERVO_GAP_US * CLK_MHZ) : 16'h0000);
	endproperty
	a_servo_gap: assert property (p_servo_gap) else $error("servo gap wrong");
	property p_cfg_cyl0;
		drv_op_valid && (drv_op == disk_ctrl_pkg::DOP_WRCFG || drv_op == disk_ctrl_pkg::DOP_RDCFG)
			|-> drv_cyl == 16'h0000;
	endproperty
	a_cfg_cyl0: assert property (p_cfg_cyl0) else $error("config op off cylinder 0");
	property p_cyl_skip0;
		drv_op_valid && (drv_op == disk_ctrl_pkg::DOP_SEEK || fmt_op)
			|-> drv_cyl != 16'h0000 && drv_cyl < cfg_image[`CFG_CYL];
	endproperty
	a_cyl_skip0: assert property (p_cyl_skip0) else $error("host cylinder out of range");
endmodule

// file: sim/drive_model.sv
// Behavioural drive engine holding the configuration of cylinder 0
`timescale 1ns/1ps
module drive_model (
	input wire logic core_clk,
	input wire logic [3:0] lat,
	input wire logic drv_op_valid,
	input wire disk_ctrl_pkg::drv_op_t drv_op,
	input wire logic [79:0] cfg_image,
	output logic drv_done = 1'b0,
	output logic drv_err = 1'b0,
	output logic drv_rvalid = 1'b0,
	output logic [7:0] drv_rdata = 8'h00
);
	logic [79:0] disk_cfg;
	logic have_cfg = 1'b0;
	always @(posedge core_clk) begin
		if (drv_op_valid === 1'b1) begin
			repeat (lat) @(posedge core_clk);
			if (drv_op == disk_ctrl_pkg::DOP_RDCFG && have_cfg) begin
				for (int k = 0; k < 10; k++) begin
					drv_rvalid <= 1'b1;
					drv_rdata <= disk_cfg[79 - 8 * k -: 8];
					@(posedge core_clk);
				end
				drv_rvalid <= 1'b0;
				drv_rdata <= ~drv_rdata;
				@(posedge core_clk);
			end
			if (drv_op == disk_ctrl_pkg::DOP_WRCFG) begin
				disk_cfg <= cfg_image;
				have_cfg <= 1'b1;
			end
			// Blank drive cannot supply a configuration
			drv_err <= drv_op == disk_ctrl_pkg::DOP_RDCFG && !have_cfg;
			drv_done <= 1'b1;
			@(posedge core_clk);
			drv_done <= 1'b0;
			drv_err <= 1'b0;
		end
	end
endmodule

// file: sim/tb_disk_ctrl_enhanced_cmd_set.sv
// Self-checking bench for the enhanced command interpreter
`timescale 1ns/1ps
`include "disk_ctrl_consts.svh"
module tb_disk_ctrl_enhanced_cmd_set;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [31:0] s_axi_rdata, d;
	logic drv_op_valid, drv_sel, drv_fill_buffer, drv_done, drv_err, drv_rvalid, ecc_uncorrectable, last_fill;
	disk_ctrl_pkg::drv_op_t drv_op;
	logic [15:0] drv_cyl, drv_gap_cycles, drv_step_cycles, last_cyl, last_step;
	logic [3:0] drv_head, last_head;
	logic [5:0] drv_sectors;
	logic [79:0] cfg_image;
	logic [7:0] drv_rdata;
	logic ecc_burst_valid = 1'b0;
	logic [3:0] ecc_burst_len = 4'h0;
	logic [3:0] lat = 4'h1;
	int failures = 0;
	int n_checks = 0;
	int n_op [0:7];
	logic [7:0] q [$];
	logic [7:0] rq [$];
	// 4 cylinders, 2 heads, 200 us step, servo, 256-byte sectors, burst 5
	localparam logic [79:0] cfg_ok = 80'h0004_02_41_01_0002_0003_05;
	localparam logic [79:0] cfg_bad = 80'h0004_00_41_01_0002_0003_05;
	always #25 core_clk = ~core_clk;
	disk_ctrl_enhanced_cmd_set #(.CLK_MHZ(20)) dut_u (.core_clk, .reset, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .drv_op_valid, .drv_op, .drv_cyl, .drv_head, .drv_sel, .drv_fill_buffer, .drv_gap_cycles,
		.drv_step_cycles, .drv_sectors, .cfg_image, .drv_done, .drv_err, .drv_rvalid, .drv_rdata,
		.ecc_burst_valid, .ecc_burst_len, .ecc_uncorrectable);
	drive_model drive_u (.core_clk, .lat, .drv_op_valid, .drv_op, .cfg_image, .drv_done, .drv_err, .drv_rvalid,
		.drv_rdata);
	always @(posedge core_clk) begin
		if (drv_op_valid === 1'b1) begin
			n_op[drv_op] = n_op[drv_op] + 1;
			if (drv_op == disk_ctrl_pkg::DOP_FORMAT) begin
				last_cyl = drv_cyl;
				last_head = drv_head;
				last_fill = drv_fill_buffer;
				last_step = drv_step_cycles;
			end
		end
	end
	task automatic chk(input logic [79:0] got, input logic [79:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
		logic aw_go, w_go;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		aw_go = 1'b1;
		w_go = 1'b1;
		while (aw_go || w_go) begin
			@(posedge core_clk);
			if (s_axi_awready === 1'b1) aw_go = 1'b0;
			if (s_axi_wready === 1'b1) w_go = 1'b0;
			s_axi_awvalid <= aw_go;
			s_axi_wvalid <= w_go;
		end
		do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge core_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic wait_req(input logic io);
		logic [31:0] v;
		logic [1:0] resp;
		do axi_rd(`OFF_STAT, v, resp); while (v[0] !== 1'b1 || v[1] !== io);
	endtask
	task automatic put(input logic [7:0] b);
		logic [1:0] resp;
		wait_req(1'b0);
		axi_wr(`OFF_DATA, {24'h0, b}, resp);
	endtask
	task automatic get(output logic [7:0] b);
		logic [31:0] v;
		logic [1:0] resp;
		wait_req(1'b1);
		axi_rd(`OFF_DATA, v, resp);
		b = v[7:0];
	endtask
	task automatic load_q(input logic [79:0] v);
		q.delete();
		for (int k = 0; k < 10; k++) q.push_back(v[79 - 8 * k -: 8]);
	endtask
	// Command block, then queued data out, nin bytes in, then status and null
	task automatic run(input logic [47:0] c, input int nin, input logic [7:0] st, input logic [7:0] ec);
		logic [7:0] b;
		logic [31:0] v;
		logic [1:0] resp;
		foreach (n_op[k]) n_op[k] = 0;
		for (int k = 0; k < 6; k++) put(c[47 - 8 * k -: 8]);
		foreach (q[k]) put(q[k]);
		rq.delete();
		repeat (nin) begin
			get(b);
			rq.push_back(b);
		end
		get(b);
		chk(b, st);
		get(b);
		chk(b, `NULL_BYTE);
		if (st == `STAT_ERR) begin
			axi_rd(`OFF_ERR, v, resp);
			chk(v[7:0], ec);
		end
		$display("test %h done", c[47:40]);
	endtask
	task automatic test_done();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge core_clk);
		reset <= 1'b0;
		wait_req(1'b0);
		axi_rd(`OFF_STAT, d, r);
		chk(d[4], 1'b0);
		axi_rd(8'h0C, d, r);
		chk({r, d}, {`RESP_SLVERR, 32'h0});
		axi_wr(8'h10, 32'h0, r);
		chk(r, `RESP_SLVERR);
		q.delete();
		run(48'h060000000000, 0, `STAT_ERR, `ERR_NOT_INIT);
		run(48'h120000000000, 0, `STAT_ERR, `ERR_NOT_INIT);
		load_q(cfg_ok);
		q = q[0:7];
		run(48'h0C0000000000, 0, `STAT_OK, `ERR_NONE);
		axi_rd(`OFF_STAT, d, r);
		chk(d[4], 1'b0);
		load_q(cfg_bad);
		run(48'h110000000000, 0, `STAT_ERR, `ERR_ILL_PARAM);
		load_q(cfg_ok);
		run(48'h110000000000, 0, `STAT_OK, `ERR_NONE);
		chk(cfg_image, cfg_ok);
		q.delete();
		run(48'h120000000000, 10, `STAT_OK, `ERR_NONE);
		for (int k = 0; k < 10; k++) chk(rq[k], cfg_ok[79 - 8 * k -: 8]);
		lat <= 4'h9;
		q = '{8'h00, 8'h03};
		run(48'h060000000020, 0, `STAT_OK, `ERR_NONE);
		chk({8'(n_op[1]), 8'(n_op[2]), 8'(n_op[3]), 8'(n_op[4])}, 32'h01010301);
		chk({last_cyl, last_head, last_fill}, {16'h0002, 4'h0, 1'b1});
		chk(last_step, 16'(`STEP_200_US * 20));
		// Start on track 4 of 6 usable: two formats then overrun
		q = '{8'h00, 8'h05};
		run(48'h060000800000, 0, `STAT_ERR, `ERR_ILL_ADDR);
		chk({8'(n_op[3]), last_cyl, last_head, last_fill}, {8'h02, 16'h0003, 4'h1, 1'b0});
		q = '{8'h00, 8'h00};
		run(48'h060000000000, 0, `STAT_OK, `ERR_NONE);
		chk({8'(n_op[3]), 8'(n_op[4])}, 16'h0001);
		q.delete();
		run(48'hFF0000000000, 0, `STAT_ERR, `ERR_BAD_CMD);
		run(48'h132000000000, 0, `STAT_OK, `ERR_NONE);
		chk(8'(n_op[6]), 8'h01);
		chk(drv_sel, 1'b1);
		ecc_burst_valid <= 1'b1;
		ecc_burst_len <= 4'h6;
		@(posedge core_clk);
		ecc_burst_len <= 4'h5;
		@(posedge core_clk);
		chk(ecc_uncorrectable, 1'b1);
		ecc_burst_valid <= 1'b0;
		@(posedge core_clk);
		chk(ecc_uncorrectable, 1'b0);
		reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		wait_req(1'b0);
		axi_rd(`OFF_STAT, d, r);
		chk(d[4], 1'b1);
		chk(cfg_image, cfg_ok);
		$display("test reload done");
		test_done();
	end
	initial begin
		repeat (60000) @(posedge core_clk);
		failures++;
		test_done();
	end
endmodule
bind disk_ctrl_enhanced_cmd_set disk_ctrl_asserts #(.CLK_MHZ(CLK_MHZ), .SERVO_GAP_US(SERVO_GAP_US)) chk_u (
	.core_clk, .reset, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rvalid,
	.drv_op_valid, .drv_op, .drv_cyl, .drv_gap_cycles, .drv_sectors, .cfg_image, .ecc_burst_valid, .ecc_burst_len,
	.ecc_uncorrectable);
